//--- rtl/aic_config_regs.sv
// general input config and channel test select registers with side effects
//
// Contract
// RULE_01: bit 12 is input three setup: 0 powered down at reset, 1 single-ended.
// RULE_02: in voltage output modes input three reads and holds 1.
// RULE_03: write leaving input three not 1 in voltage mode raises the flag.
// RULE_04: bit 11 is input four setup: 0 powered down, 1 single-ended.
// RULE_05: bits 10:8 pair setup: 000 off, 100 differential, 001-011 reserved.
// RULE_06: pair codes 101-111 are discarded, old value kept, flag raised.
// RULE_07: bits 7:6 pick differential range, code 00 depends on selector.
// RULE_08: policy 0: overcurrent gives high impedance, retries every 6 ms.
// RULE_09: policy 1: overcurrent clears output mode to 0000 until rewritten.
// RULE_10: six 2-bit diag fields, input one 23:22 down to six 13:12.
// RULE_11: diag code: 00 off, 01 ground, 10 high supply, 11 both.
// RULE_12: bits 11:8 select adc channel; a changing write aborts conversion.
// RULE_13: output mode 0000 high impedance, 0001 and 0010 voltage modes.
// RULE_14: reserved bits read zero and ignore writes.
// RULE_15: config invalid flag stays set until software clears it.
`timescale 1ns/1ps
`include "aic_map.svh"

module aic_config_regs #(
  parameter int unsigned RETRY_CYCLES = `AIC_RETRY_CYCLES
) (
  // clock and reset
  input  wire logic                 mclk,
  input  wire logic                 rst_n,
  // register access
  input  wire aic_pkg::aic_req_t    reg_req,
  output logic [23:0]               reg_rdata,
  output logic                      reg_rvalid,
  // fault and flag handling
  input  wire logic                 ovc_fault,
  input  wire logic                 flag_clear,
  output logic                      config_invalid_flag,
  // output stage and adc
  output logic [3:0]                ao_mode_out,
  output logic                      adc_abort,
  output aic_pkg::aic_analog_t      analog
);
  import aic_pkg::*;

  localparam int unsigned TW = $clog2(RETRY_CYCLES + 1);
  localparam logic [TW-1:0] RETRY_LAST = TW'(RETRY_CYCLES - 1);

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic is_voltage(input logic [3:0] m);
    is_voltage = (m == `AIC_AO_V25) || (m == `AIC_AO_V12);  // [RULE_13]
  endfunction

  function automatic logic ao_code_ok(input logic [3:0] m);
    ao_code_ok = (m == `AIC_AO_HIZ) || is_voltage(m) ||
                 (m == `AIC_AO_I25) || (m == `AIC_AO_I2);
  endfunction

  // ****************************************************************
  // state
  // ****************************************************************
  logic [3:0]     output_mode_field_q;
  logic           input_three_setup_q;
  logic           input_four_setup_q;
  logic [2:0]     pair_five_six_setup_q;
  logic [1:0]     diff_range_select_q;
  logic           overcurrent_policy_q;
  logic [11:0]    diag_q;
  logic [3:0]     adc_channel_selector_q;
  logic           flag_q;
  aic_ovc_state_t ovc_q;
  aic_ovc_state_t ovc_d;
  logic [TW-1:0]  timer_q;
  logic [TW-1:0]  timer_d;

  // ****************************************************************
  // write decode
  // ****************************************************************
  wire logic        wr_gic  = reg_req.wr &&
                              (reg_req.addr == `AIC_GIC_OFFSET);
  wire logic        wr_cts  = reg_req.wr &&
                              (reg_req.addr == `AIC_CTS_OFFSET);
  wire logic [3:0]  ao_wr   = reg_req.wdata[`AIC_AO_LSB +: 4];
  wire logic [2:0]  pair_wr = reg_req.wdata[`AIC_PAIR_LSB +: 3];
  wire logic [3:0]  sel_wr  = reg_req.wdata[`AIC_SEL_LSB +: 4];
  wire logic        ao_ok   = ao_code_ok(ao_wr);
  wire logic [3:0]  ao_new  = ao_ok ? ao_wr : output_mode_field_q;
  wire logic        volt_new = is_voltage(ao_new);
  wire logic        ai3_bad = wr_gic && volt_new &&
                              !reg_req.wdata[`AIC_AI3_BIT];   // [RULE_03]
  wire logic        pair_bad = wr_gic &&
                              (pair_wr >= `AIC_PAIR_BAD_MIN); // [RULE_06]
  wire logic        ao_bad  = wr_gic && !ao_ok;
  wire logic        flag_set = ai3_bad || pair_bad || ao_bad;
  wire logic        sel_change = wr_cts &&
                              (sel_wr != adc_channel_selector_q); // [RULE_12]

  // ****************************************************************
  // overcurrent handling
  // ****************************************************************
  // only voltage modes react; current modes have their own limiting
  wire logic fault_now = ovc_fault && (ovc_q == AIC_OVC_RUN) &&
                         is_voltage(output_mode_field_q);
  wire logic host_trip = fault_now && overcurrent_policy_q;  // [RULE_09]
  wire logic auto_trip = fault_now && !overcurrent_policy_q; // [RULE_08]
  wire logic retry_due = (ovc_q == AIC_OVC_WAIT) && (timer_q == RETRY_LAST);

  always_comb begin
    ovc_d   = ovc_q;
    timer_d = timer_q;
    case (ovc_q)
      AIC_OVC_RUN: begin
        timer_d = '0;
        if (auto_trip) begin
          ovc_d = AIC_OVC_WAIT;                               // [RULE_08]
        end
      end
      AIC_OVC_WAIT: begin
        // each retry samples the fault; still present restarts the wait
        if (retry_due) begin
          timer_d = '0;
          if (!ovc_fault) begin
            ovc_d = AIC_OVC_RUN;                              // [RULE_08]
          end
        end else begin
          timer_d = timer_q + 1'b1;
        end
      end
      default: begin
        ovc_d   = AIC_OVC_RUN;
        timer_d = '0;
      end
    endcase
  end

  // ****************************************************************
  // next values of the output mode and effective output
  // ****************************************************************
  // a trip in host policy beats a same-cycle write: protection first
  wire logic [3:0] ao_mode_d = host_trip ? `AIC_AO_HIZ :
                               wr_gic ? ao_new : output_mode_field_q;
  wire logic [3:0] ao_out_d  = (ovc_d == AIC_OVC_WAIT) ? `AIC_AO_HIZ :
                               ao_mode_d;                     // [RULE_08]

  // ****************************************************************
  // read mux
  // ****************************************************************
  wire logic [23:0] gic_rd = {4'h0, output_mode_field_q, 3'h0,
                              input_three_setup_q, input_four_setup_q,
                              pair_five_six_setup_q, diff_range_select_q,
                              2'h0, overcurrent_policy_q, 3'h0}; // [RULE_14]
  wire logic [23:0] cts_rd = {diag_q, adc_channel_selector_q,
                              8'h00};                         // [RULE_14]
  wire logic [23:0] rdata_d =
    (reg_req.addr == `AIC_GIC_OFFSET) ? gic_rd :
    (reg_req.addr == `AIC_CTS_OFFSET) ? cts_rd : 24'h000000;

  // ****************************************************************
  // general input config register
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      output_mode_field_q   <= `AIC_AO_HIZ;
      input_three_setup_q   <= 1'b0;                          // [RULE_01]
      input_four_setup_q    <= 1'b0;                          // [RULE_04]
      pair_five_six_setup_q <= `AIC_PAIR_OFF;                 // [RULE_05]
      diff_range_select_q   <= `AIC_RANGE_RST;
      overcurrent_policy_q  <= 1'b0;
    end else begin
      output_mode_field_q <= ao_mode_d;                       // [RULE_09]
      if (wr_gic) begin
        // voltage mode forces input three on whatever was written
        input_three_setup_q <= volt_new ||
                               reg_req.wdata[`AIC_AI3_BIT];   // [RULE_02]
        input_four_setup_q  <= reg_req.wdata[`AIC_AI4_BIT];   // [RULE_04]
        if (!pair_bad) begin
          pair_five_six_setup_q <= pair_wr;                   // [RULE_06]
        end
        diff_range_select_q  <= reg_req.wdata[`AIC_RANGE_LSB +: 2];
        overcurrent_policy_q <= reg_req.wdata[`AIC_OVC_BIT];
      end
    end
  end

  // ****************************************************************
  // channel test select register
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      diag_q                 <= {6{`AIC_DIAG_OFF}};          // [RULE_10]
      adc_channel_selector_q <= `AIC_SEL_NONE;                // [RULE_12]
    end else if (wr_cts) begin
      diag_q                 <= reg_req.wdata[`AIC_DIAG_LSB +: 12];
      adc_channel_selector_q <= sel_wr;
    end
  end

  // ****************************************************************
  // flag, overcurrent state and outputs
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      flag_q      <= 1'b0;
      ovc_q       <= AIC_OVC_RUN;
      timer_q     <= '0;
      ao_mode_out <= `AIC_AO_HIZ;
      adc_abort   <= 1'b0;
      reg_rdata   <= 24'h000000;
      reg_rvalid  <= 1'b0;
    end else begin
      // set wins over a clear in the same cycle
      flag_q      <= flag_set || (flag_q && !flag_clear);    // [RULE_15]
      ovc_q       <= ovc_d;
      timer_q     <= timer_d;
      ao_mode_out <= ao_out_d;
      adc_abort   <= sel_change;                              // [RULE_12]
      reg_rvalid  <= reg_req.rd;
      reg_rdata   <= reg_req.rd ? rdata_d : 24'h000000;
    end
  end

  assign config_invalid_flag = flag_q;

  // ****************************************************************
  // analog controls
  // ****************************************************************
  aic_decode u_decode (
    .mclk                 (mclk),
    .rst_n                (rst_n),
    .input_three_setup    (input_three_setup_q),
    .input_four_setup     (input_four_setup_q),
    .pair_five_six_setup  (pair_five_six_setup_q),
    .diff_range_select    (diff_range_select_q),
    .diag_fields          (diag_q),
    .adc_channel_selector (adc_channel_selector_q),
    .analog               (analog)
  );

endmodule

//--- rtl/aic_map.svh
// offsets, field positions, reset values and timing counts of the config bank
`ifndef AIC_MAP_SVH
`define AIC_MAP_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define AIC_GIC_OFFSET    8'h02
`define AIC_CTS_OFFSET    8'h03

// ****************************************************************
// general_input_config field positions (lsb)
// ****************************************************************
`define AIC_AO_LSB        16
`define AIC_AI3_BIT       12
`define AIC_AI4_BIT       11
`define AIC_PAIR_LSB      8
`define AIC_RANGE_LSB     6
`define AIC_OVC_BIT       3

// ****************************************************************
// channel_test_select field positions (lsb)
// ****************************************************************
`define AIC_DIAG_LSB      12
`define AIC_SEL_LSB       8

// ****************************************************************
// codes and reset values
// ****************************************************************
`define AIC_AO_HIZ        4'h0
`define AIC_AO_V25        4'h1
`define AIC_AO_V12        4'h2
`define AIC_AO_I25        4'h6
`define AIC_AO_I2         4'h8
`define AIC_PAIR_OFF      3'h0
`define AIC_PAIR_DIFF     3'h4
`define AIC_PAIR_BAD_MIN  3'h5
`define AIC_SEL_NONE      4'h0
`define AIC_SEL_PAIR_HI   4'h9
`define AIC_SEL_PAIR_LO   4'hC
`define AIC_DIAG_OFF      2'h0
`define AIC_RANGE_RST     2'h0

// ****************************************************************
// timing
// ****************************************************************
`define AIC_CLK_MHZ       250
`define AIC_RETRY_MS      6
`define AIC_RETRY_CYCLES  (`AIC_RETRY_MS * `AIC_CLK_MHZ * 1000)

`endif

//--- rtl/aic_pkg.sv
// types shared by the analog input config bank
package aic_pkg;

  // register access from the serial host interface
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [23:0] wdata;
  } aic_req_t;

  // differential range as seen by the gain amplifier
  typedef enum logic [2:0] {
    AIC_RNG_NONE = 3'h0,
    AIC_RNG_12V5 = 3'h1,
    AIC_RNG_2V5  = 3'h2,
    AIC_RNG_500M = 3'h3,
    AIC_RNG_250M = 3'h4,
    AIC_RNG_125M = 3'h5
  } aic_range_t;

  // decoded controls toward the analog front end
  typedef struct packed {
    logic        input_three_on;
    logic        input_four_on;
    logic        pair_diff_on;
    aic_range_t  diff_range;
    logic [5:0]  diag_to_ground;
    logic [5:0]  diag_to_high;
    logic [3:0]  adc_channel;
  } aic_analog_t;

  // overcurrent handling in automatic policy
  typedef enum logic [1:0] {
    AIC_OVC_RUN  = 2'b01,
    AIC_OVC_WAIT = 2'b10
  } aic_ovc_state_t;

endpackage

//--- rtl/aic_decode.sv
// registered decode of stored fields into analog front end controls
`timescale 1ns/1ps
`include "aic_map.svh"

module aic_decode (
  // clock and reset
  input  wire logic                 mclk,
  input  wire logic                 rst_n,
  // stored fields
  input  wire logic                 input_three_setup,
  input  wire logic                 input_four_setup,
  input  wire logic [2:0]           pair_five_six_setup,
  input  wire logic [1:0]           diff_range_select,
  input  wire logic [11:0]          diag_fields,
  input  wire logic [3:0]           adc_channel_selector,
  // decoded controls
  output aic_pkg::aic_analog_t      analog
);
  import aic_pkg::*;

  aic_analog_t analog_d;
  aic_range_t  range_d;
  logic [5:0]  gnd_d;
  logic [5:0]  high_d;

  // ****************************************************************
  // range decode
  // ****************************************************************
  // code 00 has meaning only with one of the two pair selector codes
  assign range_d =
    (diff_range_select == 2'h1) ? AIC_RNG_500M :
    (diff_range_select == 2'h2) ? AIC_RNG_250M :
    (diff_range_select == 2'h3) ? AIC_RNG_125M :
    (adc_channel_selector == `AIC_SEL_PAIR_HI) ? AIC_RNG_12V5 :
    (adc_channel_selector == `AIC_SEL_PAIR_LO) ? AIC_RNG_2V5 :
    AIC_RNG_NONE; // [RULE_07]

  // ****************************************************************
  // diagnostic switches, field 0 is input one at the top bits
  // ****************************************************************
  genvar i;
  generate
    for (i = 0; i < 6; i++) begin : g_diag
      assign gnd_d[i]  = diag_fields[2*(5-i)];     // [RULE_11]
      assign high_d[i] = diag_fields[2*(5-i)+1];   // [RULE_11]
    end
  endgenerate

  assign analog_d.input_three_on = input_three_setup;   // [RULE_01]
  assign analog_d.input_four_on  = input_four_setup;    // [RULE_04]
  assign analog_d.pair_diff_on   =
    (pair_five_six_setup == `AIC_PAIR_DIFF);            // [RULE_05]
  assign analog_d.diff_range     = range_d;
  assign analog_d.diag_to_ground = gnd_d;
  assign analog_d.diag_to_high   = high_d;
  assign analog_d.adc_channel    = adc_channel_selector;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      analog <= '0;
    end else begin
      analog <= analog_d;
    end
  end

endmodule

//--- tb/aic_config_regs_checker.sv
// port assertions for the config register bank
`timescale 1ns/1ps
`include "aic_map.svh"

module aic_config_regs_checker #(
  parameter int unsigned RETRY_CYCLES = `AIC_RETRY_CYCLES
) (
  // clock and reset
  input wire logic                 mclk,
  input wire logic                 rst_n,
  // register access
  input wire aic_pkg::aic_req_t    reg_req,
  input wire logic [23:0]          reg_rdata,
  input wire logic                 reg_rvalid,
  // fault and flag
  input wire logic                 ovc_fault,
  input wire logic                 flag_clear,
  input wire logic                 config_invalid_flag,
  // output stage and adc
  input wire logic [3:0]           ao_mode_out,
  input wire logic                 adc_abort,
  input wire aic_pkg::aic_analog_t analog
);
  import aic_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  wire gic_wr  = reg_req.wr && reg_req.addr == `AIC_GIC_OFFSET;
  wire volt_wr = gic_wr && reg_req.wdata[19:16] inside {4'h1, 4'h2};
  wire bad_pr  = gic_wr && reg_req.wdata[10:8] >= `AIC_PAIR_BAD_MIN;
  wire cts_wr  = reg_req.wr && reg_req.addr == `AIC_CTS_OFFSET;

  chk_ai3_forced: assert property (
    reg_rvalid && $past(reg_req.addr) == `AIC_GIC_OFFSET
    && reg_rdata[19:16] inside {4'h1, 4'h2} |-> reg_rdata[12])
    else $error("input three not forced in voltage mode");
  chk_ai3_flag: assert property (
    volt_wr && !reg_req.wdata[12] |=> config_invalid_flag)
    else $error("flag missing after input three write");
  chk_pair_flag: assert property (bad_pr |=> config_invalid_flag)
    else $error("flag missing after bad pair code");
  chk_pair_legal: assert property (
    reg_rvalid && $past(reg_req.addr) == `AIC_GIC_OFFSET
    |-> reg_rdata[10:8] < 3'h5)
    else $error("pair field holds a discarded code");
  chk_gic_reserved: assert property (
    reg_rvalid && $past(reg_req.addr) == `AIC_GIC_OFFSET
    |-> {reg_rdata[23:20], reg_rdata[15:13], reg_rdata[5:4],
         reg_rdata[2:0]} == 12'h000)
    else $error("reserved bits of general register not zero");
  chk_cts_reserved: assert property (
    reg_rvalid && $past(reg_req.addr) == `AIC_CTS_OFFSET
    |-> reg_rdata[7:0] == 8'h00)
    else $error("reserved bits of channel register not zero");
  chk_flag_sticky: assert property (
    config_invalid_flag && !flag_clear |=> config_invalid_flag)
    else $error("flag dropped without clear");
  chk_abort_cause: assert property (adc_abort |-> $past(cts_wr))
    else $error("abort without channel register write");
  chk_ovc_trip: assert property (
    ovc_fault && ao_mode_out inside {4'h1, 4'h2} |=> ao_mode_out == 4'h0)
    else $error("output not high impedance after overcurrent");
endmodule

bind aic_config_regs aic_config_regs_checker #(
  .RETRY_CYCLES(RETRY_CYCLES)
) chk_u (
  .mclk(mclk), .rst_n(rst_n), .reg_req(reg_req),
  .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .ovc_fault(ovc_fault), .flag_clear(flag_clear),
  .config_invalid_flag(config_invalid_flag),
  .ao_mode_out(ao_mode_out), .adc_abort(adc_abort), .analog(analog)
);

//--- tb/aic_host_model.sv
// host side of the register access: one request per call
`timescale 1ns/1ps

module aic_host_model (
  // clock
  input  wire logic             mclk,
  // register access
  output aic_pkg::aic_req_t     reg_req,
  input  wire logic [23:0]      reg_rdata,
  input  wire logic             reg_rvalid
);
  import aic_pkg::*;
  initial reg_req = '0;
  // idle lines show the inverse of the last word, never a stale copy
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [23:0] d, output logic [23:0] q);
    @(posedge mclk);
    reg_req <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge mclk);
    reg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    q = 'x;
    // the answer stands for one cycle only, right after the taking edge
    if (!w) begin
      #1;
      q = reg_rvalid ? reg_rdata : 24'hXXXXXX;
    end
  endtask
endmodule

//--- tb/analog_io_config_registers_test.sv
// self-checking bench for the config register bank
`timescale 1ns/1ps
`include "aic_map.svh"

module analog_io_config_registers_test;
  import aic_pkg::*;
  localparam logic [7:0] GIC = `AIC_GIC_OFFSET;
  localparam logic [7:0] CTS = `AIC_CTS_OFFSET;
  logic        mclk = 0, rst_n = 0, ovc_fault = 0, flag_clear = 0;
  logic [23:0] reg_rdata;
  logic        reg_rvalid, flag, abort;
  logic [3:0]  ao;
  aic_req_t    req;
  aic_analog_t analog;
  int          error_cnt = 0, comparisons = 0, n;
  logic [1:0]  c;
  aic_range_t  ex [4] = '{AIC_RNG_12V5, AIC_RNG_500M, AIC_RNG_250M,
                          AIC_RNG_125M};

  always #2 mclk = ~mclk;

  aic_host_model host_u (.mclk(mclk), .reg_req(req),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
  aic_config_regs #(.RETRY_CYCLES(16)) dut_u (
    .mclk(mclk), .rst_n(rst_n), .reg_req(req), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .ovc_fault(ovc_fault),
    .flag_clear(flag_clear), .config_invalid_flag(flag),
    .ao_mode_out(ao), .adc_abort(abort), .analog(analog));

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // write returns just after the taking edge, read compares the answer
  task automatic wr(input logic [7:0] a, input logic [23:0] d);
    logic [23:0] q;
    host_u.xfer(1'b1, a, d, q);
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [23:0] e);
    logic [23:0] q;
    host_u.xfer(1'b0, a, 24'h000000, q);
    chk(q, e);
  endtask
  task automatic settle;
    @(posedge mclk);
    #1;
  endtask
  task automatic clr;
    @(posedge mclk) flag_clear <= 1'b1;
    @(posedge mclk) flag_clear <= 1'b0;
    settle();
    chk(flag, 1'b0);
  endtask
  task automatic trip;
    @(posedge mclk) ovc_fault <= 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    chk(ao, 4'h0);
  endtask

  initial begin
    repeat (5000) @(posedge mclk);
    error_cnt++;
    end_sim();
  end

  // ****************************************************************
  // scenarios
  // ****************************************************************
  initial begin
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    rd(GIC, 24'h000000);
    rd(CTS, 24'h000000);
    wr(GIC, 24'hF0FC7F);
    chk(flag, 1'b0);
    settle();
    chk({analog.input_three_on, analog.input_four_on,
         analog.pair_diff_on}, 3'b111);
    rd(GIC, 24'h001C48);
    wr(CTS, 24'h000900);
    for (int i = 3; i >= 0; i--) begin
      wr(GIC, 24'h001C00 | (i << 6));
      settle();
      chk(analog.diff_range, ex[i]);
    end
    wr(CTS, 24'h000C00);
    chk(abort, 1'b1);
    settle();
    chk(analog.diff_range, AIC_RNG_2V5);
    for (int i = 0; i < 4; i++) begin
      c = i[1:0];
      wr(CTS, {{6{c}}, 4'hC, 8'hFF});
      chk(abort, 1'b0);
      settle();
      chk(analog.diag_to_ground, {6{c[0]}});
      chk(analog.diag_to_high, {6{c[1]}});
      chk(analog.adc_channel, 4'hC);
      rd(CTS, {{6{c}}, 4'hC, 8'h00});
    end
    wr(GIC, 24'h000D00);
    chk(flag, 1'b1);
    repeat (3) @(posedge mclk);
    rd(GIC, 24'h000C00);
    chk(flag, 1'b1);
    clr();
    wr(GIC, 24'h010000);
    chk(flag, 1'b1);
    chk(ao, 4'h1);
    rd(GIC, 24'h011000);
    clr();
    wr(GIC, 24'h021000);
    chk(flag, 1'b0);
    chk(ao, 4'h2);
    trip();
    repeat (20) @(posedge mclk);
    #1;
    chk(ao, 4'h0);
    @(posedge mclk) ovc_fault <= 1'b0;
    n = 0;
    while (ao !== 4'h2 && n < 40) begin
      settle();
      n++;
    end
    chk(ao, 4'h2);
    if (n == 40)
      end_sim();
    rd(GIC, 24'h021000);
    wr(GIC, 24'h021008);
    trip();
    @(posedge mclk) ovc_fault <= 1'b0;
    rd(GIC, 24'h001008);
    repeat (20) @(posedge mclk);
    #1;
    chk(ao, 4'h0);
    wr(GIC, 24'h011008);
    chk(ao, 4'h1);
    wr(GIC, 24'h0F1008);
    chk(flag, 1'b1);
    chk(ao, 4'h1);
    wr(GIC, 24'h061008);
    @(posedge mclk) ovc_fault <= 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    chk(ao, 4'h6);
    @(posedge mclk) ovc_fault <= 1'b0;
    rd(GIC, 24'h061008);
    rd(8'h07, 24'h000000);
    end_sim();
  end
endmodule
